// file: hw/srhf_pkg.sv
package srhf_pkg;
  // Device clock and fixed serial rate
  localparam int unsigned DEV_CLK_HZ = 3686400;
  localparam int unsigned BAUD_RATE = 9600;
  // Sixteen bit clocks per bit time
  localparam int unsigned BITCLK_PER_BIT = 16;
  localparam int unsigned BITCLK_DIV = DEV_CLK_HZ / (BAUD_RATE * BITCLK_PER_BIT);
  localparam logic [4:0] BITCLK_LAST = 5'(BITCLK_DIV - 1);
  // Default start-up delay lengths in device clocks
  localparam int unsigned PWRT_CYCLES_DEF = 256;
  localparam int unsigned OST_CYCLES_DEF = 1024;
  // Internal reset sequence last count; the sequence lasts 16 device clocks
  localparam logic [3:0] RSTSEQ_LAST = 4'hF;
  // Link timeout in bit times while a packet waits on the host
  localparam int unsigned LINK_TIMEOUT_BITS_DEF = 2048;
  // Reported carrier status encodings, low means carrier present
  localparam logic CD_PRESENT = 1'h0;
  localparam logic CD_ABSENT = 1'h1;
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    SRHF_RESET = 5'h01,
    SRHF_PWRT = 5'h02,
    SRHF_OST = 5'h04,
    SRHF_RSTSEQ = 5'h08,
    SRHF_RUN = 5'h10
  } srhf_state_t;
endpackage

// file: hw/srhf_delay_counter.sv
`timescale 1ns/1ps
`default_nettype none
// Down counter that flags done after a loaded length has elapsed
module srhf_delay_counter #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [WIDTH-1:0] length,
  output logic done
);
  // Remaining cycles
  logic [WIDTH-1:0] count;
  logic running;
  wire at_zero = (count == '0);

  // Load on start, count down while running
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      count <= length;
      running <= 1'b1;
      done <= 1'b0;
    end else if (running) begin
      count <= count - 1'b1;
      running <= !at_zero;
      done <= at_zero;
    end else begin
      done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: hw/srhf_top.sv
// Functional notes
// - Host request-to-send low means ready
// - Request-to-send handled locally, never forwarded
// - Carrier-detect sampled and reported to primary
// - Carrier-detect active low, status encoded alike
// - Fixed 9600 baud from 3.6864 MHz
// - Power-up timer, then oscillator start-up timer
// - No traffic accepted before both delays finish
// - Held in reset while reset pin low
// - Internal reset sequence before normal operation
// - Forward packet only while request-to-send low
`timescale 1ns/1ps
`default_nettype none
module srhf_top
  import srhf_pkg::*;
#(
  parameter int unsigned PWRT_CYCLES = PWRT_CYCLES_DEF,
  parameter int unsigned OST_CYCLES = OST_CYCLES_DEF,
  parameter int unsigned LINK_TIMEOUT_BITS = LINK_TIMEOUT_BITS_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rts_n,
  input wire logic cd_n,
  input wire logic host_rx_activity,
  input wire logic ir_rx_activity,
  input wire logic packet_pending,
  output logic comm_enable,
  output logic host_traffic_ok,
  output logic ir_traffic_ok,
  output logic forward_to_host,
  output logic link_cd_status,
  output logic link_timeout,
  output logic bitclk_tick,
  output logic baud_tick
);
  // Sequencer state
  srhf_state_t state;
  srhf_state_t next_state;
  // Reset-sequence counter
  logic [3:0] rstseq_count;
  // Start pulses for the two delay counters
  logic pwrt_start;
  logic ost_start;
  logic pwrt_done;
  logic ost_done;
  // Bit clock divider and bit-time counter
  logic [4:0] bitclk_div;
  logic [3:0] bit_phase;
  // Link timeout counter in bit times
  logic [15:0] wait_bits;

  // Decoding of state and strobes
  wire in_run = (state == SRHF_RUN);
  wire rts_ready = (rts_n == 1'b0);
  wire div_wrap = (bitclk_div == BITCLK_LAST);
  wire bit_wrap = div_wrap && (bit_phase == 4'hF);
  wire waiting = in_run && packet_pending && !rts_ready;
  wire timeout_hit = (wait_bits == 16'(LINK_TIMEOUT_BITS - 1));

  // Power-up timer runs first
  srhf_delay_counter #(.WIDTH(16)) u_pwrt (
    .clk(clk),
    .rst_n(rst_n),
    .start(pwrt_start),
    .length(16'(PWRT_CYCLES - 1)),
    .done(pwrt_done)
  );

  // Oscillator start-up timer runs second
  srhf_delay_counter #(.WIDTH(16)) u_oscillator_startup_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(ost_start),
    .length(16'(OST_CYCLES - 1)),
    .done(ost_done)
  );

  // Next-state selection
  always_comb begin
    next_state = state;
    pwrt_start = 1'b0;
    ost_start = 1'b0;
    unique case (state)
      SRHF_RESET: begin
        next_state = SRHF_PWRT;
        pwrt_start = 1'b1;
      end
      SRHF_PWRT: begin
        if (pwrt_done) begin
          next_state = SRHF_OST;
          ost_start = 1'b1;
        end
      end
      SRHF_OST: begin
        if (ost_done) begin
          next_state = SRHF_RSTSEQ;
        end
      end
      SRHF_RSTSEQ: begin
        if (rstseq_count == RSTSEQ_LAST) begin
          next_state = SRHF_RUN;
        end
      end
      SRHF_RUN: begin
        next_state = SRHF_RUN;
      end
      default: begin
        next_state = SRHF_RESET;
      end
    endcase
  end

  // State register; reset pin low pins it in reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= SRHF_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Internal reset-sequence counter
  always_ff @(posedge clk) begin
    if (!rst_n || state != SRHF_RSTSEQ) begin
      rstseq_count <= 4'h0;
    end else begin
      rstseq_count <= rstseq_count + 4'h1;
    end
  end

  // Bit clock divider, idle until running so no early ticks
  always_ff @(posedge clk) begin
    if (!rst_n || !in_run) begin
      bitclk_div <= 5'h00;
      bit_phase <= 4'h0;
    end else begin
      bitclk_div <= div_wrap ? 5'h00 : bitclk_div + 5'h01;
      bit_phase <= div_wrap ? bit_phase + 4'h1 : bit_phase;
    end
  end

  // Timing strobes, registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bitclk_tick <= 1'b0;
      baud_tick <= 1'b0;
    end else begin
      bitclk_tick <= in_run && div_wrap;
      baud_tick <= in_run && bit_wrap;
    end
  end

  // Gating of both interfaces until start-up is over
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      comm_enable <= 1'b0;
      host_traffic_ok <= 1'b0;
      ir_traffic_ok <= 1'b0;
    end else begin
      comm_enable <= in_run;
      host_traffic_ok <= in_run && host_rx_activity;
      ir_traffic_ok <= in_run && ir_rx_activity;
    end
  end

  // Carrier status to primary; idle reports absent
  // Request-to-send is never mixed in here, it stays local
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link_cd_status <= CD_ABSENT;
    end else begin
      link_cd_status <= in_run ? cd_n : CD_ABSENT;
    end
  end

  // Forwarding gate and link timeout
  always_ff @(posedge clk) begin
    if (!rst_n || !waiting) begin
      wait_bits <= 16'h0000;
    end else if (bit_wrap && !timeout_hit) begin
      wait_bits <= wait_bits + 16'h0001;
    end
  end

  // Timeout is sticky until the next reset: the link is dropped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      forward_to_host <= 1'b0;
      link_timeout <= 1'b0;
    end else begin
      forward_to_host <= in_run && packet_pending && rts_ready && !link_timeout;
      link_timeout <= link_timeout || (waiting && bit_wrap && timeout_hit);
    end
  end

  // Checks
  AST_RESET_HOLD: assert property (@(posedge clk) !rst_n |=> state == SRHF_RESET)
    else $error("state left reset while pin low");
  AST_NO_EARLY_COMM: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(in_run) |-> !comm_enable && !host_traffic_ok && !ir_traffic_ok)
    else $error("traffic accepted before start-up finished");
  sequence s_pwrt_end;
    state == SRHF_PWRT && pwrt_done;
  endsequence
  AST_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
    s_pwrt_end |=> state == SRHF_OST)
    else $error("oscillator timer did not follow power-up timer");
  AST_OST_AFTER_PWRT: assert property (@(posedge clk) disable iff (!rst_n)
    state == SRHF_OST |-> $past(state) inside {SRHF_PWRT, SRHF_OST})
    else $error("oscillator timer entered out of order");
  AST_RUN_AFTER_SEQ: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(in_run) |-> $past(state) == SRHF_RSTSEQ)
    else $error("run entered without reset sequence");
  AST_CD_REPORT: assert property (@(posedge clk) disable iff (!rst_n)
    in_run |=> link_cd_status == $past(cd_n))
    else $error("carrier status mismatch");
  AST_FWD_RTS: assert property (@(posedge clk) disable iff (!rst_n)
    forward_to_host |-> $past(rts_n) == 1'b0)
    else $error("forwarded while host not ready");
  // Disconnect is sticky and keeps forwarding shut until reset
  AST_TIMEOUT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    link_timeout |=> link_timeout && !forward_to_host)
    else $error("forwarding resumed after link timeout");
  // Quiet stretch between bit clocks: 23 idle cycles, split to keep repeats small
  sequence s_bitclk_gap;
    !bitclk_tick [*8] ##1 !bitclk_tick [*8] ##1 !bitclk_tick [*7];
  endsequence
  // Leaving run only happens through reset, which disables this check
  AST_BAUD: assert property (@(posedge clk) disable iff (!rst_n)
    bitclk_tick |=> s_bitclk_gap ##1 bitclk_tick)
    else $error("bit clock spacing wrong");
endmodule
`default_nettype wire

// file: tb/srhf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host UART handshake lines, steered by bench controls
module srhf_host_model (
  input wire logic ready,
  input wire logic carrier,
  input wire logic send,
  input wire logic rude,
  input wire logic comm_enable,
  output logic rts_n,
  output logic cd_n,
  output logic host_rx_activity
);
  // Low while the host can take data
  assign rts_n = ~ready;
  // Low while a carrier is present
  assign cd_n = ~carrier;
  // Polite host waits for start-up; rude mode breaks that on purpose
  assign host_rx_activity = send & (comm_enable | rude);
endmodule
`default_nettype wire

// file: tb/srhf_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module srhf_top_tb;
  import srhf_pkg::*;
  // Short delays keep the run brief
  localparam int PW = 8, OS = 16, LT = 2;
  logic clk, rst_n, ready, carrier, send, rude, ir_act, pend;
  logic rts_n, cd_n, h_act, ce, h_ok, i_ok, fwd, cds, tmo, bck, bd;
  logic [5:0] q[$]; // Expected output notes, oldest first
  logic [5:0] e;
  logic [31:0] v;
  int miscompares = 0, comparisons = 0, cyc = 0, seed = 88, n, nb, nk;
  srhf_host_model host (.ready(ready), .carrier(carrier), .send(send), .rude(rude),
    .comm_enable(ce), .rts_n(rts_n), .cd_n(cd_n), .host_rx_activity(h_act));
  srhf_top #(.PWRT_CYCLES(PW), .OST_CYCLES(OS), .LINK_TIMEOUT_BITS(LT)) dut (
    .clk(clk), .rst_n(rst_n), .rts_n(rts_n), .cd_n(cd_n), .host_rx_activity(h_act),
    .ir_rx_activity(ir_act), .packet_pending(pend), .comm_enable(ce),
    .host_traffic_ok(h_ok), .ir_traffic_ok(i_ok), .forward_to_host(fwd),
    .link_cd_status(cds), .link_timeout(tmo), .bitclk_tick(bck), .baud_tick(bd));
  // 25 MHz clock
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task chk(input string s, input logic [15:0] x, input logic [15:0] g);
    comparisons++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", s, x, g);
    end
  endtask
  task finish_test();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  // Oldest note against the settled outputs
  always @(negedge clk) begin
    if (q.size() > 0) chk("outputs", 16'(q.pop_front()), {ce, h_ok, i_ok, fwd, cds, tmo});
  end
  // Drive {ready,carrier,send,ir,pend}, note result one edge later
  task step(input logic [4:0] in, input logic [5:0] x);
    @(posedge clk);
    #1 {ready, carrier, send, ir_act, pend} = in;
    @(posedge clk);
    q.push_back(x);
  endtask
  // Bounded wait for start-up; traffic must stay refused meanwhile
  task wait_up();
    n = 0;
    while (ce !== 1'b1 && n < 200) begin
      @(posedge clk);
      #2 n++;
      if (ce !== 1'b1) chk("early traffic", 0, {h_ok, i_ok, fwd});
    end
    chk("start-up length", 1, n >= PW + OS + 17 && n <= PW + OS + 25);
  endtask
  initial begin
    {rst_n, ready, carrier, send, ir_act, pend} = '0;
    rude = 1;
    step(5'h1F, 6'h02);
    step(5'h1F, 6'h02);
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    wait_up();
    rude = 0;
    // Random handshake and carrier levels
    repeat (24) begin
      v = $random(seed);
      e = {1'b1, v[2], v[1], v[0] & v[4], ~v[3], 1'b0};
      step(v[4:0], e);
    end
    // Tick rates over ten bit times
    step(5'h10, 6'h22);
    nb = 0;
    nk = 0;
    repeat (3840) begin
      @(posedge clk);
      #2 nb += bd;
      nk += bck;
    end
    chk("baud ticks", 10, nb);
    chk("bit clock ticks", 160, nk);
    // Host never ready while a packet waits
    step(5'h01, 6'h22);
    n = 0;
    while (tmo !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #2 n++;
    end
    chk("timeout wait", 1, n >= (LT - 1) * 384 && n <= (LT + 1) * 384);
    step(5'h11, 6'h23);
    // Reset in mid-run clears the disconnect
    #1 rst_n = 0;
    step(5'h1F, 6'h02);
    #1 rst_n = 1;
    wait_up();
    step(5'h11, 6'h26);
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule
`default_nettype wire
